// *** design/irq_pkg.sv ***
// Constants, register map and state layout of the vectored interrupt controller.
// Assumes a 32-bit Avalon-MM slave port whose registers each take one aligned word.
package irq_pkg;
   localparam int NUM_FLAG_REGS = 5;
   localparam int NUM_PRIO_SLOTS = 19;
   localparam int NUM_SOURCES = 80;
   localparam int NUM_EXT = 3;
   localparam int NUM_TRAPS = 4;

   // Byte offsets
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_FLAG_BASE = 8'h08;
   localparam logic [7:0] OFF_ENABLE_BASE = 8'h1c;
   localparam logic [7:0] OFF_PRIO_BASE = 8'h30;
   localparam logic [7:0] OFF_PENDING = 8'h7c;
   localparam logic [7:0] OFF_CPU_LEVEL = 8'h80;
   localparam logic [7:0] OFF_EVT_STATUS = 8'h84;
   localparam logic [7:0] OFF_EVT_MASK = 8'h88;

   // Field positions
   localparam int POS_NESTING_DISABLE = 15;
   localparam int POS_TRAP_LO = 1;
   localparam int POS_ALT_TABLE = 15;
   localparam int POS_IPL_LO = 5;
   localparam int POS_IPL_TOP = 3;
   localparam int POS_PEND_LEVEL = 8;
   localparam int POS_EVT_REQ = 0;
   localparam int POS_EVT_TRAP = 1;

   // Writable bits of the control, priority and flag registers
   localparam logic [15:0] MASK_CTRL_A = 16'h801e;
   localparam logic [15:0] MASK_CTRL_B = 16'h8007;
   localparam logic [15:0] MASK_PRIO = 16'h7777;
   localparam logic [4:0][15:0] MASK_FLAG = {16'hffff, 16'hffff, 16'h22e3, 16'hfe1f, 16'hffff};

   // Flag slots of the external inputs, as {register, bit}
   localparam logic [NUM_EXT-1:0][2:0] EXT_REG = {3'h1, 3'h1, 3'h0};
   localparam logic [NUM_EXT-1:0][3:0] EXT_BIT = {4'hd, 4'h4, 4'h0};

   // Reset values, and the CPU level that nesting disable forces
   localparam logic [15:0] RST_REG = 16'h0000;
   localparam logic [2:0] RST_IPL = 3'h0;
   localparam logic [2:0] IPL_NEST_BLOCK = 3'h7;

   typedef struct packed {
      logic [15:0]                     ctrl_a;
      logic [15:0]                     ctrl_b;
      logic [NUM_FLAG_REGS-1:0][15:0]  flag;
      logic [NUM_FLAG_REGS-1:0][15:0]  enable;
      logic [NUM_PRIO_SLOTS-1:0][15:0] prio;
      logic [2:0]                      cpu_priority_level;
      logic [6:0]                      pend_vec;
      logic [3:0]                      pend_lvl;
      logic                            req;
      logic [1:0]                      evt_stat;
      logic [1:0]                      evt_mask;
      logic                            irq;
      logic                            waitreq;
      logic [31:0]                     rdata;
      logic [NUM_EXT-1:0]              sync1;
      logic [NUM_EXT-1:0]              sync2;
      logic [NUM_EXT-1:0]              ext_prev;
   } state_type;
endpackage

// *** design/arb_if.sv ***
// Carrier between the register file and the priority arbiter.
// Assumes both ends sit on the same clock; the bundle is purely combinational.
interface arb_if;
   logic [79:0]       active;
   logic [79:0][2:0]  prio;
   logic [3:0]        cpu_lvl;
   logic              win_valid;
   logic [6:0]        win_vec;
   logic [3:0]        win_lvl;

   modport requester (output active, output prio, output cpu_lvl,
                      input win_valid, input win_vec, input win_lvl);
   modport arbiter (input active, input prio, input cpu_lvl,
                    output win_valid, output win_vec, output win_lvl);
endinterface

// *** design/priority_arbiter.sv ***
// Picks the highest-priority active source above the current CPU level.
// Assumes active already combines flag and enable; purely combinational.
module priority_arbiter (
   arb_if.arbiter bus
);
   logic [3:0] best_lvl;
   logic [6:0] best_vec;
   logic       found;

   always_comb begin
      best_lvl = bus.cpu_lvl;
      best_vec = 7'h00;
      found = 1'b0;
      // Strict compare while scanning upward keeps the lowest vector on a tie
      for (int i = 0; i < 80; i++) begin
         if (bus.active[i] && ({1'b0, bus.prio[i]} > best_lvl)) begin // [RULE15]
            best_lvl = {1'b0, bus.prio[i]};
            best_vec = 7'(i);
            found = 1'b1;
         end
      end
   end

   assign bus.win_valid = found;
   assign bus.win_vec = best_vec;
   assign bus.win_lvl = best_lvl;
endmodule

// *** design/irq_controller.sv ***
// Vectored interrupt controller: flags, enables, priorities, pending vector.
// Assumes peripherals pulse src_req on clk_sys, external pins are asynchronous,
// and the CPU pulses cpu_ack on clk_sys when it takes the presented vector.

// Behaviour
// RULE1: There are 29 registers: two control, five flag, five enable, 16 priority, one pending.
// RULE2: The first global control register holds nesting disable and the trap flags.
// RULE3: The second global control register sets external input edges and alternate table use.
// RULE4: Each source has one flag, set by hardware and cleared only by a software write.
// RULE5: Each source has its own enable bit so it can be allowed or blocked alone.
// RULE6: Each user source has a 3-bit priority choosing one of eight levels.
// RULE7: The pending-vector register captures a 7-bit vector number and a 4-bit level.
// RULE8: The captured level equals the pending source's priority and becomes the new CPU level.
// RULE9: Flag, enable and priority positions follow vector order, vector 0 at bit 0 and bits 2:0.
// RULE10: The CPU level's low three bits sit at bits 7:5 and software may write them.
// RULE11: The fourth CPU level bit is read-only so software cannot mask traps.
// RULE12: Flags read 1 after a request, 0 otherwise, are read-write and reset to 0.
// RULE13: Flag register 1 holds its twelve named sources with bits 8 to 5 reading zero.
// RULE14: Flag register 2 holds its seven named sources with every other bit reading zero.
// RULE15: A flagged, enabled source above the CPU level is presented; lowest vector wins ties.
// RULE16: Unimplemented flag bits ignore writes and read zero.
module irq_controller (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [79:0] src_req,
   input  wire logic [2:0]  ext_pin,
   input  wire logic [3:0]  trap_evt,
   input  wire logic        cpu_ack,
   output logic             cpu_irq_req,
   output logic      [6:0]  cpu_vector,
   output logic      [3:0]  cpu_level,
   output logic             alt_vector_sel,
   output logic             irq
);
   irq_pkg::state_type state_q;
   irq_pkg::state_type state_d;
   arb_if              arb ();

   logic [5:0]  word_idx;
   logic [15:0] rd_val;
   logic        acc_wr;
   logic        acc_rd;
   logic        ipl_top;
   logic [79:0] set_req;
   logic [79:0] flag_flat;
   logic [79:0] en_flat;

   // Slots 13, 14 and 17 are holes in the priority bank
   function automatic logic prio_impl(input logic [5:0] slot);
      return (slot < 6'd13) || (slot == 6'd15) || (slot == 6'd16) || (slot == 6'd18);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wdata,
                                         input logic [3:0] be, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (be[0]) begin
         v[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         v[15:8] = wdata[15:8];
      end
      return v & mask;
   endfunction

   function automatic logic [5:0] idx_of(input logic [7:0] off);
      return off[7:2];
   endfunction

   assign word_idx = idx_of(avs_address);
   assign acc_wr = avs_write && !state_q.waitreq;
   assign acc_rd = avs_read && !state_q.waitreq;

   // Any live trap lifts the CPU level above every user priority
   assign ipl_top = |state_q.ctrl_a[irq_pkg::POS_TRAP_LO +: irq_pkg::NUM_TRAPS]; // [RULE11]

   assign flag_flat = state_q.flag;
   assign en_flat = state_q.enable;

   // Arbiter inputs
   always_comb begin
      arb.active = flag_flat & en_flat; // [RULE5]
      for (int v = 0; v < 80; v++) begin
         // Vector v lives in slot v/4, field v%4; holes and vectors 76 to 79 (no slot) stay at level 0
         if (v / 4 < irq_pkg::NUM_PRIO_SLOTS) begin
            arb.prio[v] = state_q.prio[v / 4][(v % 4) * 4 +: 3]; // [RULE9] [RULE6]
         end else begin
            arb.prio[v] = 3'h0;
         end
      end
      arb.cpu_lvl = {ipl_top, state_q.cpu_priority_level}; // [RULE10] [RULE11]
   end

   priority_arbiter u_arbiter (
      .bus (arb)
   );

   // Hardware set terms: peripheral requests plus synchronised external edges
   always_comb begin
      logic [2:0] r;
      logic [3:0] b;
      logic       rise;
      logic       fall;
      r = 3'h0;
      b = 4'h0;
      rise = 1'b0;
      fall = 1'b0;
      set_req = src_req;
      for (int e = 0; e < irq_pkg::NUM_EXT; e++) begin
         r = irq_pkg::EXT_REG[e];
         b = irq_pkg::EXT_BIT[e];
         rise = state_q.sync2[e] && !state_q.ext_prev[e];
         fall = !state_q.sync2[e] && state_q.ext_prev[e];
         // Polarity bit 1 selects the falling edge
         if (state_q.ctrl_b[e] ? fall : rise) begin // [RULE3]
            set_req[{r, b}] = 1'b1;
         end
      end
   end

   // Register read mux
   always_comb begin
      rd_val = 16'h0000;
      if (avs_address[1:0] == 2'b00) begin
         if (avs_address == irq_pkg::OFF_CTRL_A) begin
            rd_val = state_q.ctrl_a;
         end else if (avs_address == irq_pkg::OFF_CTRL_B) begin
            rd_val = state_q.ctrl_b;
         end else if (avs_address == irq_pkg::OFF_PENDING) begin
            rd_val[6:0] = state_q.pend_vec; // [RULE7]
            rd_val[irq_pkg::POS_PEND_LEVEL +: 4] = state_q.pend_lvl;
         end else if (avs_address == irq_pkg::OFF_CPU_LEVEL) begin
            rd_val[irq_pkg::POS_IPL_LO +: 3] = state_q.cpu_priority_level;
            rd_val[irq_pkg::POS_IPL_TOP] = ipl_top;
         end else if (avs_address == irq_pkg::OFF_EVT_STATUS) begin
            rd_val[1:0] = state_q.evt_stat;
         end else if (avs_address == irq_pkg::OFF_EVT_MASK) begin
            rd_val[1:0] = state_q.evt_mask;
         end else begin
            for (int k = 0; k < irq_pkg::NUM_FLAG_REGS; k++) begin
               if (word_idx == idx_of(irq_pkg::OFF_FLAG_BASE) + 6'(k)) begin
                  rd_val = state_q.flag[k]; // [RULE12]
               end
               if (word_idx == idx_of(irq_pkg::OFF_ENABLE_BASE) + 6'(k)) begin
                  rd_val = state_q.enable[k];
               end
            end
            for (int p = 0; p < irq_pkg::NUM_PRIO_SLOTS; p++) begin
               if (word_idx == idx_of(irq_pkg::OFF_PRIO_BASE) + 6'(p) && prio_impl(6'(p))) begin
                  rd_val = state_q.prio[p];
               end
            end
         end
      end
   end

   // Next-state logic
   always_comb begin
      logic [1:0] evt_set;
      logic [3:0] trap_set;
      evt_set = 2'b00;
      trap_set = 4'h0;
      state_d = state_q;

      // Two-stage synchroniser; only sync2 and its delayed copy ext_prev are looked at by logic
      state_d.sync1 = ext_pin;
      state_d.sync2 = state_q.sync1;
      state_d.ext_prev = state_q.sync2;

      // Bus handshake: one wait cycle; reads latch data on the release edge, writes land one edge later
      if ((avs_read || avs_write) && state_q.waitreq) begin
         state_d.waitreq = 1'b0;
         state_d.rdata = avs_read ? {16'h0000, rd_val} : 32'h0000_0000;
      end else begin
         state_d.waitreq = 1'b1;
      end

      // Software writes
      if (acc_wr) begin
         if (avs_address == irq_pkg::OFF_CTRL_A) begin
            state_d.ctrl_a = merge(state_q.ctrl_a, avs_writedata, avs_byteenable,
                                   irq_pkg::MASK_CTRL_A); // [RULE2]
         end
         if (avs_address == irq_pkg::OFF_CTRL_B) begin
            state_d.ctrl_b = merge(state_q.ctrl_b, avs_writedata, avs_byteenable,
                                   irq_pkg::MASK_CTRL_B); // [RULE3]
         end
         if (avs_address == irq_pkg::OFF_CPU_LEVEL && avs_byteenable[0]) begin
            // Top level bit is not writable
            state_d.cpu_priority_level = avs_writedata[irq_pkg::POS_IPL_LO +: 3]; // [RULE10] [RULE11]
         end
         if (avs_address == irq_pkg::OFF_EVT_MASK && avs_byteenable[0]) begin
            state_d.evt_mask = avs_writedata[1:0];
         end
         for (int k = 0; k < irq_pkg::NUM_FLAG_REGS; k++) begin
            if (avs_address == irq_pkg::OFF_FLAG_BASE + 8'(4 * k)) begin
               // Unimplemented positions are masked away [RULE16] [RULE13] [RULE14]
               state_d.flag[k] = merge(state_q.flag[k], avs_writedata, avs_byteenable,
                                       irq_pkg::MASK_FLAG[k]); // [RULE4]
            end
            if (avs_address == irq_pkg::OFF_ENABLE_BASE + 8'(4 * k)) begin
               state_d.enable[k] = merge(state_q.enable[k], avs_writedata, avs_byteenable,
                                         16'hffff); // [RULE5]
            end
         end
         for (int p = 0; p < irq_pkg::NUM_PRIO_SLOTS; p++) begin
            if (avs_address == irq_pkg::OFF_PRIO_BASE + 8'(4 * p) && prio_impl(6'(p))) begin
               state_d.prio[p] = merge(state_q.prio[p], avs_writedata, avs_byteenable,
                                       irq_pkg::MASK_PRIO); // [RULE6] [RULE1]
            end
         end
      end

      // Hardware sets win over a same-cycle software clear
      for (int k = 0; k < irq_pkg::NUM_FLAG_REGS; k++) begin
         state_d.flag[k] = state_d.flag[k] |
                           (set_req[k * 16 +: 16] & irq_pkg::MASK_FLAG[k]); // [RULE4]
      end
      trap_set = trap_evt;
      state_d.ctrl_a[irq_pkg::POS_TRAP_LO +: irq_pkg::NUM_TRAPS] =
         state_d.ctrl_a[irq_pkg::POS_TRAP_LO +: irq_pkg::NUM_TRAPS] | trap_set; // [RULE2]

      // Present the winner and latch its vector and level
      state_d.req = arb.win_valid; // [RULE15]
      if (arb.win_valid) begin
         state_d.pend_vec = arb.win_vec; // [RULE7]
         state_d.pend_lvl = arb.win_lvl; // [RULE8]
      end

      // Taking the vector raises the CPU level; nesting disable blocks all further users
      if (cpu_ack && state_q.req) begin
         if (state_q.ctrl_a[irq_pkg::POS_NESTING_DISABLE]) begin // [RULE2]
            state_d.cpu_priority_level = irq_pkg::IPL_NEST_BLOCK;
         end else begin
            state_d.cpu_priority_level = state_q.pend_lvl[2:0]; // [RULE8]
         end
      end

      // Event status: read clears only what was returned, so a fresh set survives
      evt_set[irq_pkg::POS_EVT_REQ] = arb.win_valid && !state_q.req;
      evt_set[irq_pkg::POS_EVT_TRAP] = |trap_evt;
      if (acc_rd && avs_address == irq_pkg::OFF_EVT_STATUS) begin
         state_d.evt_stat = state_q.evt_stat & ~state_q.rdata[1:0];
      end
      state_d.evt_stat = state_d.evt_stat | evt_set;
      state_d.irq = |(state_d.evt_stat & state_d.evt_mask);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q.ctrl_a <= irq_pkg::RST_REG;
         state_q.ctrl_b <= irq_pkg::RST_REG;
         state_q.flag <= '0; // [RULE12]
         state_q.enable <= '0;
         state_q.prio <= '0;
         state_q.cpu_priority_level <= irq_pkg::RST_IPL;
         state_q.pend_vec <= 7'h00;
         state_q.pend_lvl <= 4'h0;
         state_q.req <= 1'b0;
         state_q.evt_stat <= 2'b00;
         state_q.evt_mask <= 2'b00;
         state_q.irq <= 1'b0;
         state_q.waitreq <= 1'b1;
         state_q.rdata <= 32'h0000_0000;
         state_q.sync1 <= 3'h0;
         state_q.sync2 <= 3'h0;
         state_q.ext_prev <= 3'h0;
      end else begin
         state_q <= state_d;
      end
   end

   assign avs_readdata = state_q.rdata;
   assign avs_waitrequest = state_q.waitreq;
   assign cpu_irq_req = state_q.req;
   assign cpu_vector = state_q.pend_vec;
   assign cpu_level = state_q.pend_lvl;
   assign alt_vector_sel = state_q.ctrl_b[irq_pkg::POS_ALT_TABLE]; // [RULE3]
   assign irq = state_q.irq;
endmodule

// *** tb/irq_monitor.sv ***
// Concurrent checks on the controller's top ports: bus handshake and request outputs.
// Assumes one clock domain; bound into every irq_controller instance.
module irq_monitor (
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        cpu_irq_req,
   input wire logic [6:0]  cpu_vector,
   input wire logic [3:0]  cpu_level,
   input wire logic        alt_vector_sel,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ctrl_b_done;
   logic evt_done;
   assign ctrl_b_done = avs_write && !avs_waitrequest && avs_address == irq_pkg::OFF_CTRL_B;
   // Mask writes drop irq as well as status reads, so both count as a cause
   assign evt_done = (avs_read || avs_write) && !avs_waitrequest &&
      (avs_address == irq_pkg::OFF_EVT_STATUS || avs_address == irq_pkg::OFF_EVT_MASK);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus answer late");
   property p_wait_short;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_short: assert property (p_wait_short) else $error("answer too long");
   property p_rdata_hi;
      avs_readdata[31:16] == 16'h0;
   endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
   property p_rdata_stands;
      $changed(avs_readdata) |-> !avs_waitrequest;
   endproperty
   a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
   property p_alt_cause;
      $changed(alt_vector_sel) |-> $past(ctrl_b_done) || $past(ctrl_b_done, 2);
   endproperty
   a_alt_cause: assert property (p_alt_cause) else $error("table select moved");
   property p_req_level;
      cpu_irq_req |-> cpu_level inside {[4'h1:4'h7]};
   endproperty
   a_req_level: assert property (p_req_level) else $error("bad pending level");
   property p_vec_range;
      cpu_irq_req |-> cpu_vector < 7'd80;
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector out of range");
   property p_vec_hold;
      $changed(cpu_vector) || $changed(cpu_level) |-> cpu_irq_req;
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("idle vector moved");
   property p_irq_fall;
      $fell(irq) |-> $past(evt_done) || $past(evt_done, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   c_req: cover property ($rose(cpu_irq_req));
   c_irq: cover property ($rose(irq));
   c_alt: cover property ($rose(alt_vector_sel));
endmodule

bind irq_controller irq_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level),
   .alt_vector_sel(alt_vector_sel), .irq(irq));

// *** tb/cpu_model.sv ***
// Processor core stand-in: takes a presented vector after a programmable stall.
// Assumes cpu_irq_req follows an acknowledge by one edge, so it skips that cycle.
module cpu_model (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       take_en,
   input  wire logic [3:0] stall,
   input  wire logic       cpu_irq_req,
   output logic            cpu_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   // One-cycle acknowledge only while a request stands; the level becomes the CPU's
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wait_q  <= 4'h0;
         cpu_ack <= 1'b0;
      end else begin
         cpu_ack <= 1'b0;
         if (!take_en || !cpu_irq_req || cpu_ack) wait_q <= 4'h0;
         else if (wait_q >= stall) begin
            cpu_ack <= 1'b1;
            wait_q  <= 4'h0;
         end else wait_q <= wait_q + 4'h1;
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the interrupt controller over Avalon-MM.
// Assumes one register access per bus call and a CPU model gated by take_en.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [79:0] src_req = '0;
   logic [2:0]  ext_pin = 3'h0;
   logic [3:0]  trap_evt = 4'h0, cpu_level;
   logic [6:0]  cpu_vector;
   logic        avs_waitrequest, cpu_ack, cpu_irq_req, alt_vector_sel, irq, take_en = 1'b0;
   int          err_count = 0, comparisons = 0;
   always #2.5 clk_sys = ~clk_sys;
   irq_controller u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .src_req(src_req), .ext_pin(ext_pin), .trap_evt(trap_evt), .cpu_ack(cpu_ack),
      .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level),
      .alt_vector_sel(alt_vector_sel), .irq(irq));
   cpu_model u_cpu (.clk_sys(clk_sys), .rst_b(rst_b), .take_en(take_en), .stall(4'h1),
      .cpu_irq_req(cpu_irq_req), .cpu_ack(cpu_ack));
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request stays up until waitrequest is sampled low; no fixed latency is assumed
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= {16'h0, d};
      avs_write     <= wr;
      avs_read      <= ~wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0, q);
      chk(q, e);
   endtask
   task automatic wait_for(input logic sel_irq, input logic e);
      int n;
      for (n = 0; n < 20 && (sel_irq ? irq : cpu_irq_req) !== e; n++) @(posedge clk_sys);
      chk({31'h0, sel_irq ? irq : cpu_irq_req}, {31'h0, e});
      if ((sel_irq ? irq : cpu_irq_req) !== e) conclude();
   endtask
   task automatic pulse(input int v);
      @(posedge clk_sys);
      src_req[v] <= 1'b1;
      @(posedge clk_sys);
      src_req[v] <= 1'b0;
   endtask
   task automatic s_flags();
      rd(irq_pkg::OFF_FLAG_BASE, 32'h0);
      wr(irq_pkg::OFF_FLAG_BASE + 8'h04, 16'hffff);
      wr(irq_pkg::OFF_FLAG_BASE + 8'h08, 16'hffff);
      rd(irq_pkg::OFF_FLAG_BASE + 8'h04, 32'hfe1f);
      rd(irq_pkg::OFF_FLAG_BASE + 8'h08, 32'h22e3);
      wr(irq_pkg::OFF_FLAG_BASE + 8'h04, 16'h0);
      wr(irq_pkg::OFF_FLAG_BASE + 8'h08, 16'h0);
      rd(irq_pkg::OFF_FLAG_BASE + 8'h08, 32'h0);
      rd(8'hfc, 32'h0);
      wr(irq_pkg::OFF_CTRL_A, 16'h8000);
      rd(irq_pkg::OFF_CTRL_A, 32'h8000);
      wr(irq_pkg::OFF_CTRL_A, 16'h0);
   endtask
   // Vectors 0 and 1 tie at level 5, vector 2 sits at 6
   task automatic s_arb();
      wr(irq_pkg::OFF_PRIO_BASE, 16'h0655);
      wr(irq_pkg::OFF_ENABLE_BASE, 16'h0002);
      pulse(0);
      pulse(1);
      wait_for(1'b0, 1'b1);
      chk({25'h0, cpu_vector}, 32'h1);
      wr(irq_pkg::OFF_ENABLE_BASE, 16'h0007);
      repeat (2) @(posedge clk_sys);
      chk({25'h0, cpu_vector}, 32'h0);
      rd(irq_pkg::OFF_PENDING, 32'h0500);
      pulse(2);
      repeat (2) @(posedge clk_sys);
      chk({28'h0, cpu_level}, 32'h6);
      chk({25'h0, cpu_vector}, 32'h2);
      rd(irq_pkg::OFF_FLAG_BASE, 32'h0007);
   endtask
   task automatic s_level();
      take_en <= 1'b1;
      wait_for(1'b0, 1'b0);
      take_en <= 1'b0;
      rd(irq_pkg::OFF_CPU_LEVEL, 32'h00c0);
      wr(irq_pkg::OFF_CPU_LEVEL, 16'h00e8);
      rd(irq_pkg::OFF_CPU_LEVEL, 32'h00e0);
      wr(irq_pkg::OFF_CPU_LEVEL, 16'h0);
      wait_for(1'b0, 1'b1);
      chk({25'h0, cpu_vector}, 32'h2);
      // With nesting disabled the taken vector must lift the level to 7, not to 6
      wr(irq_pkg::OFF_CTRL_A, 16'h8000);
      take_en <= 1'b1;
      wait_for(1'b0, 1'b0);
      take_en <= 1'b0;
      rd(irq_pkg::OFF_CPU_LEVEL, 32'h00e0);
      wr(irq_pkg::OFF_CTRL_A, 16'h0);
      wr(irq_pkg::OFF_CPU_LEVEL, 16'h0);
   endtask
   task automatic s_clear_irq();
      wr(irq_pkg::OFF_FLAG_BASE, 16'h0);
      wait_for(1'b0, 1'b0);
      wr(irq_pkg::OFF_EVT_MASK, 16'h0001);
      wait_for(1'b1, 1'b1);
      rd(irq_pkg::OFF_EVT_STATUS, 32'h0001);
      wait_for(1'b1, 1'b0);
   endtask
   task automatic s_ext_trap();
      // Input 1 listens for falling edges, so its rise must leave no flag
      wr(irq_pkg::OFF_CTRL_B, 16'h8002);
      ext_pin <= 3'h3;
      repeat (6) @(posedge clk_sys);
      chk({31'h0, alt_vector_sel}, 32'h1);
      rd(irq_pkg::OFF_FLAG_BASE, 32'h1);
      rd(irq_pkg::OFF_FLAG_BASE + 8'h04, 32'h0);
      ext_pin <= 3'h1;
      repeat (6) @(posedge clk_sys);
      rd(irq_pkg::OFF_FLAG_BASE + 8'h04, 32'h0010);
      trap_evt <= 4'h1;
      @(posedge clk_sys);
      trap_evt <= 4'h0;
      rd(irq_pkg::OFF_CTRL_A, 32'h0002);
      rd(irq_pkg::OFF_CPU_LEVEL, 32'h0008);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      s_flags();
      s_arb();
      s_level();
      s_clear_irq();
      s_ext_trap();
      conclude();
   end
endmodule
